// ===== logic/drmu_pkg.sv
// Shared constants and types for the drive register math unit
`default_nettype none
package drmu_pkg;
   localparam int DATA_W = 32;
   localparam int SHORT_W = 16;
   localparam int ACC_IDX = 0;
   localparam logic [31:0] DATA_RST = 32'h0000_0000;
   // Most negative long is outside the documented load range
   localparam logic [31:0] LONG_EXCLUDED = 32'h8000_0000;
   localparam logic signed [31:0] SHORT_MAX = 32'sh0000_7FFF;
   localparam logic signed [31:0] SHORT_MIN = 32'shFFFF_8001;
   localparam int DEC_DIGITS = 10;
   localparam logic [31:0] DEC_BASE = 32'h0000_000A;
   localparam logic [7:0] CH_R = 8'h52;
   localparam logic [7:0] CH_X = 8'h58;
   localparam logic [7:0] CH_EQ = 8'h3D;
   localparam logic [7:0] CH_MINUS = 8'h2D;
   localparam logic [7:0] CH_ZERO = 8'h30;
   // Reply phases
   localparam logic [2:0] PH_R = 3'h0;
   localparam logic [2:0] PH_X = 3'h1;
   localparam logic [2:0] PH_NAME = 3'h2;
   localparam logic [2:0] PH_EQ = 3'h3;
   localparam logic [2:0] PH_SIGN = 3'h4;
   localparam logic [2:0] PH_DIG = 3'h5;
   localparam logic [2:0] PH_END = 3'h6;
   typedef enum logic [2:0] {OP_LOAD, OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_AND} drmu_op_t;
   typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_CONV, ST_EMIT} drmu_state_t;
endpackage
`default_nettype wire

// ===== logic/drmu_divider.sv
// Iterative unsigned restoring divider, one quotient bit per cycle
`timescale 1ns/1ps
`default_nettype none
module drmu_divider #(
   parameter int W = 32
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [W-1:0] dividend,
   input wire logic [W-1:0] divisor,
   output logic done,
   output logic [W-1:0] quotient,
   output logic [W-1:0] remainder
);
   localparam int CW = $clog2(W + 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(W);
   localparam logic [CW-1:0] CNT_ONE = CW'(1);

   logic [W-1:0] den_q;
   logic [CW-1:0] cnt_q;
   logic busy_q;
   logic [W:0] shifted;
   logic [W:0] diff;

   // Shift in the next dividend bit and try the subtraction
   assign shifted = {remainder, quotient[W-1]};
   assign diff = shifted - {1'b0, den_q};

   // Quotient and remainder shift registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         quotient <= '0;
         remainder <= '0;
         den_q <= '0;
      end else if (start) begin
         quotient <= dividend;
         remainder <= '0;
         den_q <= divisor;
      end else if (busy_q) begin
         if (!diff[W]) begin
            remainder <= diff[W-1:0];
            quotient <= {quotient[W-2:0], 1'b1};
         end else begin
            remainder <= shifted[W-1:0];
            quotient <= {quotient[W-2:0], 1'b0};
         end
      end
   end

   // Step counter and completion pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         busy_q <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            cnt_q <= CNT_FULL;
            busy_q <= 1'b1;
         end else if (busy_q) begin
            cnt_q <= cnt_q - CNT_ONE;
            if (cnt_q == CNT_ONE) begin
               busy_q <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule // drmu_divider
`default_nettype wire

// ===== logic/drmu_core.sv
// Data register load, arithmetic and read-back reply unit
`timescale 1ns/1ps
`default_nettype none
module drmu_core #(
   parameter int NREG = 64,
   parameter int IDX_W = $clog2(NREG),
   parameter logic [NREG-1:0] SHORT_MASK = '0,
   parameter logic [NREG-1:0] RO_MASK = '0
) (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic CMD_VALID,
   output logic CMD_READY,
   input wire drmu_pkg::drmu_op_t CMD_OP,
   input wire logic CMD_HAS_VALUE,
   input wire logic [IDX_W-1:0] CMD_REG_A,
   input wire logic [IDX_W-1:0] CMD_REG_B,
   input wire logic [7:0] CMD_REG_NAME,
   input wire logic [31:0] CMD_VALUE,
   output logic CMD_DONE,
   output logic CMD_ERR,
   output logic CC_TRUE,
   output logic CC_FALSE,
   output logic CC_NEGATIVE,
   output logic CC_POSITIVE,
   output logic CC_ZERO,
   output logic [31:0] ACC_VALUE,
   output logic RPL_VALID,
   output logic [7:0] RPL_CHAR,
   output logic RPL_LAST,
   input wire logic RPL_READY
);
   import drmu_pkg::*;

   logic [DATA_W-1:0] reg_q [NREG];
   drmu_state_t state_q;
   logic [7:0] name_q;
   logic neg_q;
   logic [DATA_W-1:0] work_q;
   logic [3:0] dig_q [DEC_DIGITS];
   logic [3:0] dcnt_q;
   logic [2:0] ph_q;
   logic div_start_q;
   logic div_done;
   logic [DATA_W-1:0] dvs_q;
   logic [DATA_W-1:0] div_quo, div_rem, div_b, opa, opb, mag_a, mag_b, alu_r, wr_val;
   logic [2*DATA_W-1:0] prod;
   logic take, is_load, range_ok, load_ok, alu_op, div_fin, wr_en, emit_step;
   logic [IDX_W-1:0] wr_idx;

   // Operand fetch and request decode
   assign opa = reg_q[CMD_REG_A];
   assign opb = reg_q[CMD_REG_B];
   assign mag_a = opa[DATA_W-1] ? -opa : opa;
   assign mag_b = opb[DATA_W-1] ? -opb : opb;
   assign take = CMD_VALID && CMD_READY;
   assign is_load = (CMD_OP == OP_LOAD);
   assign alu_op = (CMD_OP == OP_ADD) || (CMD_OP == OP_SUB) || (CMD_OP == OP_MUL) || (CMD_OP == OP_AND);
   assign div_fin = (state_q == ST_DIV) && div_done;
   assign emit_step = (state_q == ST_EMIT) && (!RPL_VALID || RPL_READY);

   // Immediate value checked as a signed long against the target's range
   assign range_ok = SHORT_MASK[CMD_REG_A] ?
      (($signed(CMD_VALUE) >= SHORT_MIN) && ($signed(CMD_VALUE) <= SHORT_MAX)) :
      (CMD_VALUE != LONG_EXCLUDED);
   assign load_ok = range_ok && !RO_MASK[CMD_REG_A];

   // 32-bit arithmetic, results wrap
   assign prod = opa * opb;
   always_comb begin
      case (CMD_OP)
         OP_ADD: alu_r = opa + opb;
         OP_SUB: alu_r = opa - opb;
         OP_MUL: alu_r = prod[DATA_W-1:0];
         OP_AND: alu_r = opa & opb;
         default: alu_r = opa;
      endcase
   end

   // Register write selection: loads, single-cycle math, divide completion
   always_comb begin
      wr_en = 1'b0;
      wr_idx = IDX_W'(ACC_IDX);
      wr_val = alu_r;
      if (take && is_load && CMD_HAS_VALUE && load_ok) begin
         wr_en = 1'b1;
         wr_idx = CMD_REG_A;
         wr_val = CMD_VALUE;
      end else if (take && alu_op) begin
         wr_en = 1'b1;
      end else if (div_fin) begin
         wr_en = 1'b1;
         wr_val = neg_q ? -div_quo : div_quo;
      end
   end

   // Data register bank; short registers keep the low half, sign-extended
   for (genvar i = 0; i < NREG; i++) begin : g_reg
      always_ff @(posedge CORE_CLK or negedge RST_N) begin
         if (!RST_N) begin
            reg_q[i] <= DATA_RST;
         end else if (wr_en && (wr_idx == IDX_W'(i))) begin
            reg_q[i] <= SHORT_MASK[i] ? {{(DATA_W-SHORT_W){wr_val[SHORT_W-1]}}, wr_val[SHORT_W-1:0]} : wr_val;
         end
      end
   end
   assign ACC_VALUE = reg_q[ACC_IDX];

   // Condition flags follow every math result written to the accumulator
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         CC_TRUE <= 1'b0;
         CC_FALSE <= 1'b0;
         CC_NEGATIVE <= 1'b0;
         CC_POSITIVE <= 1'b0;
         CC_ZERO <= 1'b0;
      end else if (wr_en && !(take && is_load)) begin
         CC_ZERO <= (wr_val == DATA_RST);
         CC_NEGATIVE <= wr_val[DATA_W-1];
         CC_POSITIVE <= !wr_val[DATA_W-1] && (wr_val != DATA_RST);
         CC_TRUE <= (wr_val != DATA_RST);
         CC_FALSE <= (wr_val == DATA_RST);
      end
   end

   // Divider operands are latched at acceptance, since the request is gone when the divider starts
   assign div_b = (state_q == ST_CONV) ? DEC_BASE : dvs_q;

   drmu_divider #(
      .W(DATA_W)
   ) u_div (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .start(div_start_q),
      .dividend(work_q),
      .divisor(div_b),
      .done(div_done),
      .quotient(div_quo),
      .remainder(div_rem)
   );

   // Command sequencer
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_q <= ST_IDLE;
         CMD_READY <= 1'b1;
         CMD_DONE <= 1'b0;
         CMD_ERR <= 1'b0;
         div_start_q <= 1'b0;
         neg_q <= 1'b0;
         name_q <= 8'h00;
         work_q <= DATA_RST;
         dvs_q <= DATA_RST;
      end else begin
         CMD_DONE <= 1'b0;
         CMD_ERR <= 1'b0;
         div_start_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (take) begin
                  if (CMD_OP == OP_DIV) begin
                     if (opb == DATA_RST) begin
                        CMD_DONE <= 1'b1;
                     end else begin
                        neg_q <= opa[DATA_W-1] ^ opb[DATA_W-1];
                        work_q <= mag_a;
                        dvs_q <= mag_b;
                        div_start_q <= 1'b1;
                        CMD_READY <= 1'b0;
                        state_q <= ST_DIV;
                     end
                  end else if (is_load && !CMD_HAS_VALUE) begin
                     neg_q <= opa[DATA_W-1];
                     work_q <= mag_a;
                     name_q <= CMD_REG_NAME;
                     div_start_q <= 1'b1;
                     CMD_READY <= 1'b0;
                     state_q <= ST_CONV;
                  end else begin
                     CMD_DONE <= 1'b1;
                     CMD_ERR <= is_load && !load_ok;
                  end
               end
            end
            ST_DIV: begin
               if (div_done) begin
                  CMD_DONE <= 1'b1;
                  CMD_READY <= 1'b1;
                  state_q <= ST_IDLE;
               end
            end
            ST_CONV: begin
               if (div_done) begin
                  if (div_quo == DATA_RST) begin
                     state_q <= ST_EMIT;
                  end else begin
                     work_q <= div_quo;
                     div_start_q <= 1'b1;
                  end
               end
            end
            ST_EMIT: begin
               if (emit_step && (ph_q == PH_END)) begin
                  CMD_DONE <= 1'b1;
                  CMD_READY <= 1'b1;
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Decimal digits, least significant first
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (int k = 0; k < DEC_DIGITS; k++) begin
            dig_q[k] <= 4'h0;
         end
      end else if ((state_q == ST_CONV) && div_done) begin
         dig_q[dcnt_q] <= div_rem[3:0];
      end
   end

   // Reply character stream with its own hand-shake
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ph_q <= PH_R;
         dcnt_q <= 4'h0;
         RPL_VALID <= 1'b0;
         RPL_CHAR <= 8'h00;
         RPL_LAST <= 1'b0;
      end else if (state_q == ST_IDLE) begin
         ph_q <= PH_R;
         dcnt_q <= 4'h0;
      end else if ((state_q == ST_CONV) && div_done) begin
         dcnt_q <= dcnt_q + 4'h1;
      end else if (emit_step) begin
         RPL_VALID <= 1'b1;
         RPL_LAST <= 1'b0;
         case (ph_q)
            PH_R: begin
               RPL_CHAR <= CH_R;
               ph_q <= PH_X;
            end
            PH_X: begin
               RPL_CHAR <= CH_X;
               ph_q <= PH_NAME;
            end
            PH_NAME: begin
               RPL_CHAR <= name_q;
               ph_q <= PH_EQ;
            end
            PH_EQ: begin
               RPL_CHAR <= CH_EQ;
               ph_q <= neg_q ? PH_SIGN : PH_DIG;
            end
            PH_SIGN: begin
               RPL_CHAR <= CH_MINUS;
               ph_q <= PH_DIG;
            end
            PH_DIG: begin
               RPL_CHAR <= CH_ZERO + {4'h0, dig_q[dcnt_q - 4'h1]};
               dcnt_q <= dcnt_q - 4'h1;
               RPL_LAST <= (dcnt_q == 4'h1);
               if (dcnt_q == 4'h1) begin
                  ph_q <= PH_END;
               end
            end
            default: begin
               RPL_VALID <= 1'b0;
               ph_q <= PH_R;
            end
         endcase
      end
   end
endmodule // drmu_core
`default_nettype wire

// ===== dv/drmu_core_properties.sv
// Concurrent property checker for the drive register math unit
`timescale 1ns/1ps
`default_nettype none
module drmu_core_properties import drmu_pkg::*; (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic CMD_VALID,
   input wire logic CMD_READY,
   input wire drmu_pkg::drmu_op_t CMD_OP,
   input wire logic CMD_HAS_VALUE,
   input wire logic CMD_DONE,
   input wire logic CMD_ERR,
   input wire logic CC_TRUE,
   input wire logic CC_FALSE,
   input wire logic CC_NEGATIVE,
   input wire logic CC_POSITIVE,
   input wire logic CC_ZERO,
   input wire logic [31:0] ACC_VALUE,
   input wire logic RPL_VALID,
   input wire logic [7:0] RPL_CHAR,
   input wire logic RPL_LAST,
   input wire logic RPL_READY
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   // Accepted command shapes and the accepted last reply character
   sequence s_take;
      CMD_VALID && CMD_READY;
   endsequence
   sequence s_math;
      s_take ##0 CMD_OP inside {OP_ADD, OP_SUB, OP_MUL, OP_AND};
   endsequence
   sequence s_div_quick;
      s_take ##0 CMD_OP == OP_DIV ##1 CMD_DONE;
   endsequence
   sequence s_reply_end;
      RPL_VALID && RPL_READY && RPL_LAST;
   endsequence
   // Completion, flags and reply stream properties
   property p_err_done; CMD_ERR |-> CMD_DONE; endproperty
   property p_math_done; s_math |=> CMD_DONE && !CMD_ERR; endproperty
   property p_flag_sign; s_math |=> CC_ZERO == (ACC_VALUE == 32'h0) && CC_NEGATIVE == ACC_VALUE[31]; endproperty
   property p_flag_tf; s_math |=> CC_TRUE == (ACC_VALUE != 32'h0) && CC_FALSE == (ACC_VALUE == 32'h0); endproperty
   property p_flag_one; $onehot0({CC_NEGATIVE, CC_POSITIVE, CC_ZERO}) && !(CC_TRUE && CC_FALSE); endproperty
   property p_div_bound; s_take ##0 CMD_OP == OP_DIV |-> ##[1:40] CMD_DONE; endproperty
   property p_div_zero; s_div_quick |-> $stable(ACC_VALUE) && $stable({CC_TRUE, CC_ZERO, CC_NEGATIVE}); endproperty
   property p_load_flags; s_take ##0 CMD_OP == OP_LOAD |=> $stable({CC_TRUE, CC_FALSE, CC_ZERO}); endproperty
   property p_rb_busy; s_take ##0 CMD_OP == OP_LOAD && !CMD_HAS_VALUE |=> !CMD_READY; endproperty
   property p_rpl_hold; RPL_VALID && !RPL_READY |=> RPL_VALID && $stable(RPL_CHAR) && $stable(RPL_LAST); endproperty
   property p_rpl_end; s_reply_end |=> CMD_DONE && !RPL_VALID && CMD_READY; endproperty
   a_err_done: assert property (p_err_done) else $error("error flag without done");
   a_math_done: assert property (p_math_done) else $error("math op not done in one cycle");
   a_flag_sign: assert property (p_flag_sign) else $error("sign or zero flag wrong");
   a_flag_tf: assert property (p_flag_tf) else $error("true or false flag wrong");
   a_flag_one: assert property (p_flag_one) else $error("flags not exclusive");
   a_div_bound: assert property (p_div_bound) else $error("divide never done");
   a_div_zero: assert property (p_div_zero) else $error("zero divisor changed state");
   a_load_flags: assert property (p_load_flags) else $error("load changed flags");
   a_rb_busy: assert property (p_rb_busy) else $error("read-back not busy");
   a_rpl_hold: assert property (p_rpl_hold) else $error("reply char not held");
   a_rpl_end: assert property (p_rpl_end) else $error("reply end not done");
endmodule // drmu_core_properties
bind drmu_core drmu_core_properties drmu_core_properties_i (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
   .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD_OP(CMD_OP), .CMD_HAS_VALUE(CMD_HAS_VALUE),
   .CMD_DONE(CMD_DONE), .CMD_ERR(CMD_ERR), .CC_TRUE(CC_TRUE), .CC_FALSE(CC_FALSE), .CC_NEGATIVE(CC_NEGATIVE),
   .CC_POSITIVE(CC_POSITIVE), .CC_ZERO(CC_ZERO), .ACC_VALUE(ACC_VALUE), .RPL_VALID(RPL_VALID),
   .RPL_CHAR(RPL_CHAR), .RPL_LAST(RPL_LAST), .RPL_READY(RPL_READY));
`default_nettype wire

// ===== dv/drmu_reply_sink.sv
// Read-back reply consumer that can stall the character stream
`timescale 1ns/1ps
`default_nettype none
module drmu_reply_sink (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic valid,
   input wire logic [7:0] ch,
   input wire logic stall,
   output logic ready
);
   logic [7:0] got[$];
   // Collects each accepted character of the reply
   always @(posedge clk) begin
      if (rst_n && valid && ready) begin
         got.push_back(ch);
      end
   end
   // Ready moves off the sampling edge; stalls every other cycle when asked
   always @(negedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ready <= 1'b0;
      end else begin
         ready <= stall ? !ready : 1'b1;
      end
   end
endmodule // drmu_reply_sink
`default_nettype wire

// ===== dv/drive_register_math_unit_test.sv
// Self-checking bench for the drive register math unit
`timescale 1ns/1ps
`default_nettype none
module drive_register_math_unit_test;
   import drmu_pkg::*;
   logic core_clk, rst_n, cmd_valid, cmd_ready, has_value, done, err, rpl_valid, rpl_last, rpl_ready, stall;
   logic cc_t, cc_f, cc_n, cc_p, cc_z;
   drmu_op_t op;
   logic [2:0] reg_a, reg_b;
   logic [7:0] reg_name, rpl_char;
   logic [31:0] value, acc;
   int miscompares, checks_done, cycles;
   assign reg_name = {5'h06, reg_a};
   drmu_core #(.NREG(8), .SHORT_MASK(8'h20), .RO_MASK(8'h40)) drmu_core_i (.CORE_CLK(core_clk), .RST_N(rst_n),
      .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OP(op), .CMD_HAS_VALUE(has_value), .CMD_REG_A(reg_a),
      .CMD_REG_B(reg_b), .CMD_REG_NAME(reg_name), .CMD_VALUE(value), .CMD_DONE(done), .CMD_ERR(err),
      .CC_TRUE(cc_t), .CC_FALSE(cc_f), .CC_NEGATIVE(cc_n), .CC_POSITIVE(cc_p), .CC_ZERO(cc_z), .ACC_VALUE(acc),
      .RPL_VALID(rpl_valid), .RPL_CHAR(rpl_char), .RPL_LAST(rpl_last), .RPL_READY(rpl_ready));
   drmu_reply_sink drmu_reply_sink_i (.clk(core_clk), .rst_n(rst_n), .valid(rpl_valid), .ch(rpl_char),
      .stall(stall), .ready(rpl_ready));
   // Clock generation
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // Hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         complete_run();
      end
   end
   // Value compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Reply text compare
   task automatic chk_str(input string exp);
      string got;
      got = "";
      foreach (drmu_reply_sink_i.got[i]) begin
         got = {got, $sformatf("%c", drmu_reply_sink_i.got[i])};
      end
      checks_done++;
      if (got != exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One command: present, wait for acceptance, release, wait for done
   task automatic cmd(input drmu_op_t o, input logic h, input logic [2:0] a, input logic [2:0] b,
      input logic [31:0] v, input logic exp_err);
      @(negedge core_clk);
      op = o;
      has_value = h;
      reg_a = a;
      reg_b = b;
      value = v;
      cmd_valid = 1'b1;
      while (!cmd_ready) @(negedge core_clk);
      @(negedge core_clk);
      cmd_valid = 1'b0;
      while (!done) @(negedge core_clk);
      chk({31'h0, err}, {31'h0, exp_err});
   endtask
   task automatic ld(input logic [2:0] a, input logic [31:0] v, input logic exp_err);
      cmd(OP_LOAD, 1'b1, a, 3'h0, v, exp_err);
   endtask
   task automatic rb(input logic [2:0] a, input string exp);
      drmu_reply_sink_i.got.delete();
      cmd(OP_LOAD, 1'b0, a, 3'h0, 32'h0, 1'b0);
      chk_str(exp);
   endtask
   // Math op with accumulator and flag expectations
   task automatic math(input drmu_op_t o, input logic [2:0] a, input logic [2:0] b, input logic [31:0] e);
      cmd(o, 1'b0, a, b, 32'h0, 1'b0);
      chk(acc, e);
      chk({27'h0, cc_t, cc_f, cc_n, cc_p, cc_z},
         {27'h0, e != 32'h0, e == 32'h0, e[31], !e[31] && e != 32'h0, e == 32'h0});
   endtask
   // Long loads, a rejected value and stalled read-back
   task automatic t_load;
      stall = 1'b1;
      ld(3'h1, 32'hFFFE_1DC0, 1'b0);
      rb(3'h1, "RX1=-123456");
      ld(3'h1, 32'h8000_0000, 1'b1);
      rb(3'h1, "RX1=-123456");
      stall = 1'b0;
      $display("t_load finished");
   endtask
   // Short register limits and read-only target
   task automatic t_short_ro;
      ld(3'h5, 32'hFFFF_8001, 1'b0);
      rb(3'h5, "RX5=-32767");
      ld(3'h5, 32'h0000_8000, 1'b1);
      ld(3'h5, 32'h0000_7FFF, 1'b0);
      rb(3'h5, "RX5=32767");
      ld(3'h6, 32'h0000_0005, 1'b1);
      rb(3'h6, "RX6=0");
      $display("t_short_ro finished");
   endtask
   // Every math command, wrap cases and zero divisor
   task automatic t_math;
      ld(3'h1, 32'h7FFF_FFFF, 1'b0);
      ld(3'h2, 32'h0000_0001, 1'b0);
      ld(3'h3, 32'h8000_0001, 1'b0);
      ld(3'h4, 32'h0000_0002, 1'b0);
      math(OP_ADD, 3'h2, 3'h4, 32'h0000_0003);
      math(OP_ADD, 3'h1, 3'h2, 32'h8000_0000);
      math(OP_ADD, 3'h0, 3'h2, 32'h8000_0001);
      math(OP_SUB, 3'h2, 3'h4, 32'hFFFF_FFFF);
      math(OP_SUB, 3'h3, 3'h4, 32'h7FFF_FFFF);
      math(OP_MUL, 3'h1, 3'h4, 32'hFFFF_FFFE);
      math(OP_DIV, 3'h3, 3'h4, 32'hC000_0001);
      math(OP_AND, 3'h1, 3'h4, 32'h0000_0002);
      math(OP_DIV, 3'h1, 3'h7, 32'h0000_0002);
      math(OP_AND, 3'h2, 3'h4, 32'h0000_0000);
      rb(3'h0, "RX0=0");
      $display("t_math finished");
   endtask
   // Verdict and end of run
   task automatic complete_run;
      $display("checks=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      rst_n = 1'b0;
      cmd_valid = 1'b0;
      op = OP_LOAD;
      has_value = 1'b0;
      reg_a = 3'h0;
      reg_b = 3'h0;
      value = 32'h0;
      stall = 1'b0;
      miscompares = 0;
      checks_done = 0;
      cycles = 0;
      repeat (4) @(negedge core_clk);
      rst_n = 1'b1;
      t_load();
      t_short_ro();
      t_math();
      complete_run();
   end
endmodule // drive_register_math_unit_test
`default_nettype wire
